// >>> hw/reset_source_combiner_status.sv
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
module reset_source_combiner_status #(
    parameter logic has_regulator_bit = 1'b1
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic brownout_reset,
    input wire logic master_clear_pin,
    input wire reset_cause_pkg::core_events_t core_events,
    input wire logic watchdog_fuse_enable,
    input wire reset_cause_pkg::reg_req_t reg_req,
    output logic [reset_cause_pkg::DATA_W-1:0] reg_rdata,
    output logic system_reset_out,
    output logic watchdog_enable,
    output logic regulator_sleep_keep,
    output logic irq
);
    import reset_cause_pkg::*;

    logic bor_meta_r;
    logic bor_s_r;
    logic pin_meta_r;
    logic pin_s_r;
    logic [DATA_W-1:0] cause_r;
    logic [DATA_W-1:0] cause_nxt;
    logic [EV_W-1:0] int_status_r;
    logic [EV_W-1:0] int_status_nxt;
    logic [EV_W-1:0] int_enable_r;
    logic [EV_W-1:0] int_enable_nxt;
    logic [EV_W-1:0] events;
    logic [DATA_W-1:0] impl_mask;
    logic [DATA_W-1:0] rdata_nxt;
    logic any_source;
    logic power_save;

    function automatic logic hit(input reg_req_t r, input logic [ADDR_W-1:0] ofs, input logic strobe);
        hit = strobe && (r.addr == ofs);
    endfunction

    // Pins are asynchronous to mclk
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            bor_meta_r <= 1'b0;
            bor_s_r <= 1'b0;
            pin_meta_r <= 1'b0;
            pin_s_r <= 1'b0;
        end
        else
        begin
            bor_meta_r <= brownout_reset;
            bor_s_r <= bor_meta_r;
            pin_meta_r <= master_clear_pin;
            pin_s_r <= pin_meta_r;
        end
    end

    assign any_source = bor_s_r | pin_s_r | core_events.trap_conflict | core_events.illegal_operation
        | core_events.reset_instruction | core_events.watchdog_timeout;
    assign power_save = core_events.power_save_sleep | core_events.power_save_idle;

    // Power-on is the asynchronous reset itself, so the output is high from the first instant
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            system_reset_out <= 1'b1;
        else
            system_reset_out <= any_source;
    end

    // Variants without the regulator bit hold it at zero
    assign impl_mask = has_regulator_bit ? CAUSE_IMPL_MASK : (CAUSE_IMPL_MASK & ~REGULATOR_MASK);

    always_comb
    begin
        cause_nxt = cause_r;
        if (hit(reg_req, CAUSE_OFS, reg_req.wr))
            cause_nxt = reg_req.wdata & impl_mask;
        // Hardware clears, then sets, come after the software write so they win
        if (power_save)
            cause_nxt[WATCHDOG_TIMEOUT_FLAG_BIT] = 1'b0;
        if (bor_s_r)
            cause_nxt = cause_nxt & ~BOR_CLEAR_MASK;
        if (core_events.trap_conflict)
            cause_nxt[TRAP_BIT] = 1'b1;
        if (core_events.illegal_operation)
            cause_nxt[ILLEGAL_BIT] = 1'b1;
        if (pin_s_r)
            cause_nxt[PIN_BIT] = 1'b1;
        if (core_events.reset_instruction)
            cause_nxt[SWR_BIT] = 1'b1;
        if (core_events.watchdog_timeout)
            cause_nxt[WATCHDOG_TIMEOUT_FLAG_BIT] = 1'b1;
        if (core_events.power_save_sleep)
            cause_nxt[SLEEP_BIT] = 1'b1;
        if (core_events.power_save_idle)
            cause_nxt[IDLE_BIT] = 1'b1;
        if (bor_s_r)
            cause_nxt[BOR_BIT] = 1'b1;
    end

    // Power-on leaves only the power-on and brown-out flags set
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            cause_r <= CAUSE_RESET;
        else
            cause_r <= cause_nxt;
    end

    // The fuse is a static configuration level, already in the mclk domain
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            watchdog_enable <= 1'b0;
            regulator_sleep_keep <= 1'b0;
        end
        else
        begin
            watchdog_enable <= watchdog_fuse_enable | cause_nxt[WDOG_EN_BIT];
            regulator_sleep_keep <= cause_nxt[REGULATOR_BIT];
        end
    end

    always_comb
    begin
        events = EV_ZERO;
        events[EV_TRAP] = core_events.trap_conflict;
        events[EV_ILLEGAL] = core_events.illegal_operation;
        events[EV_PIN] = pin_s_r;
        events[EV_SWR] = core_events.reset_instruction;
        events[EV_WATCHDOG_TIMEOUT_FLAG] = core_events.watchdog_timeout;
        events[EV_BOR] = bor_s_r;
        events[EV_SLEEP] = core_events.power_save_sleep;
        events[EV_IDLE] = core_events.power_save_idle;
    end

    always_comb
    begin
        int_status_nxt = int_status_r;
        if (hit(reg_req, INT_CLEAR_OFS, reg_req.wr))
            int_status_nxt = int_status_r & ~reg_req.wdata[EV_W-1:0];
        // An event in the clearing cycle survives
        int_status_nxt = int_status_nxt | events;
        int_enable_nxt = int_enable_r;
        if (hit(reg_req, INT_ENABLE_OFS, reg_req.wr))
            int_enable_nxt = reg_req.wdata[EV_W-1:0];
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            int_status_r <= EV_ZERO;
            int_enable_r <= EV_ZERO;
            irq <= 1'b0;
        end
        else
        begin
            int_status_r <= int_status_nxt;
            int_enable_r <= int_enable_nxt;
            irq <= |(int_status_nxt & int_enable_nxt);
        end
    end

    always_comb
    begin
        rdata_nxt = DATA_ZERO;
        if (hit(reg_req, CAUSE_OFS, reg_req.rd))
            rdata_nxt = cause_r;
        else if (hit(reg_req, INT_STATUS_OFS, reg_req.rd))
            rdata_nxt = {{(DATA_W-EV_W){1'b0}}, int_status_r};
        else if (hit(reg_req, INT_ENABLE_OFS, reg_req.rd))
            rdata_nxt = {{(DATA_W-EV_W){1'b0}}, int_enable_r};
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            reg_rdata <= DATA_ZERO;
        else
            reg_rdata <= rdata_nxt;
    end

    logic cause_wr;
    assign cause_wr = hit(reg_req, CAUSE_OFS, reg_req.wr);

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    system_reset_out_follow_a: assert property (any_source |=> system_reset_out)
        else $error("system reset not raised after source");
    system_reset_out_quiet_a: assert property (!any_source |=> !system_reset_out)
        else $error("system reset raised without source");
    trap_wins_a: assert property (core_events.trap_conflict |=> cause_r[TRAP_BIT])
        else $error("trap flag not set");
    bor_clears_a: assert property (bor_s_r && !core_events.trap_conflict && !core_events.illegal_operation
        |=> !cause_r[TRAP_BIT] && !cause_r[ILLEGAL_BIT] && cause_r[BOR_BIT])
        else $error("brown-out did not clear or set flags");
    pin_keep_a: assert property (bor_s_r && !pin_s_r && !cause_wr |=> cause_r[PIN_BIT] == $past(cause_r[PIN_BIT]))
        else $error("brown-out disturbed pin flag");
    watchdog_timeout_flag_clear_a: assert property (power_save && !core_events.watchdog_timeout |=> !cause_r[WATCHDOG_TIMEOUT_FLAG_BIT])
        else $error("power-save did not clear watchdog flag");
    por_hold_a: assert property (!cause_wr |=> cause_r[POR_BIT] == $past(cause_r[POR_BIT]))
        else $error("power-on flag changed by hardware");
    unimpl_zero_a: assert property (cause_r[13:9] == 5'h0)
        else $error("unimplemented bits not zero");
    wdog_fuse_a: assert property (watchdog_fuse_enable |=> watchdog_enable)
        else $error("fuse did not force watchdog");
    sw_write_a: assert property (cause_wr && !any_source && !power_save
        |=> cause_r == ($past(reg_req.wdata) & impl_mask) && !system_reset_out)
        else $error("software write not stored or caused reset");
    irq_level_a: assert property (irq == |(int_status_r & int_enable_r))
        else $error("interrupt level mismatch");

    trap_cover_c: cover property (core_events.trap_conflict ##1 system_reset_out);
    bor_cover_c: cover property (bor_s_r ##1 cause_r[BOR_BIT]);
    race_cover_c: cover property (cause_wr && core_events.watchdog_timeout);
    irq_cover_c: cover property (!irq ##1 irq);

endmodule

// >>> hw/reset_cause_pkg.sv
package reset_cause_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int EV_W = 8;

    // Register offsets (byte addresses on the plain register port)
    localparam logic [ADDR_W-1:0] CAUSE_OFS = 4'h0;
    localparam logic [ADDR_W-1:0] INT_STATUS_OFS = 4'h4;
    localparam logic [ADDR_W-1:0] INT_CLEAR_OFS = 4'h8;
    localparam logic [ADDR_W-1:0] INT_ENABLE_OFS = 4'hC;

    // Field positions of reset_cause_control
    localparam int TRAP_BIT = 15;
    localparam int ILLEGAL_BIT = 14;
    localparam int REGULATOR_BIT = 8;
    localparam int PIN_BIT = 7;
    localparam int SWR_BIT = 6;
    localparam int WDOG_EN_BIT = 5;
    localparam int WATCHDOG_TIMEOUT_FLAG_BIT = 4;
    localparam int SLEEP_BIT = 3;
    localparam int IDLE_BIT = 2;
    localparam int BOR_BIT = 1;
    localparam int POR_BIT = 0;

    localparam logic [DATA_W-1:0] CAUSE_RESET = 16'h0003;
    localparam logic [DATA_W-1:0] CAUSE_IMPL_MASK = 16'hC1FF;
    localparam logic [DATA_W-1:0] REGULATOR_MASK = 16'h0100;
    localparam logic [DATA_W-1:0] BOR_CLEAR_MASK = 16'hC05C;
    localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;

    // Interrupt event positions
    localparam int EV_TRAP = 0;
    localparam int EV_ILLEGAL = 1;
    localparam int EV_PIN = 2;
    localparam int EV_SWR = 3;
    localparam int EV_WATCHDOG_TIMEOUT_FLAG = 4;
    localparam int EV_BOR = 5;
    localparam int EV_SLEEP = 6;
    localparam int EV_IDLE = 7;
    localparam logic [EV_W-1:0] EV_ZERO = 8'h00;

    typedef struct packed {
        logic trap_conflict;
        logic illegal_operation;
        logic reset_instruction;
        logic watchdog_timeout;
        logic power_save_sleep;
        logic power_save_idle;
    } core_events_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

endpackage

// >>> verif/source_model.sv
`timescale 1ns/100ps
module source_model (
    input wire logic mclk,
    input wire logic rst,
    input wire logic go,
    input wire logic [2:0] kind,
    output reset_cause_pkg::core_events_t core_events,
    output logic brownout_reset,
    output logic master_clear_pin
);
    import reset_cause_pkg::*;
    logic [2:0] hold_r;
    logic bor_sel_r;
    // Core events last one cycle; pin sources are held so the two-flop sync cannot miss them
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            core_events <= core_events_t'(6'h00);
            hold_r <= 3'h0;
            bor_sel_r <= 1'b0;
        end
        else
        begin
            core_events <= core_events_t'((go && kind < 3'h6) ? 6'h20 >> kind : 6'h00);
            if (go && kind >= 3'h6)
            begin
                hold_r <= 3'h4;
                bor_sel_r <= kind[0];
            end
            else if (hold_r != 3'h0)
                hold_r <= hold_r - 3'h1;
        end
    end
    assign brownout_reset = hold_r != 3'h0 && bor_sel_r;
    assign master_clear_pin = hold_r != 3'h0 && !bor_sel_r;
endmodule

// >>> verif/testbench.sv
`timescale 1ns/100ps
module testbench;
    import reset_cause_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic go = 1'b0;
    logic [2:0] kind = 3'h0;
    logic fuse = 1'b0;
    reg_req_t req = '0;
    core_events_t ev;
    logic bor, pin, sro, wde, keep, irq;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] rdata2;
    logic keep2;
    logic [15:0] c;
    logic [31:0] seed = 32'he5a0;
    int fail_count = 0;
    int check_count = 0;
    int rcnt = 0;
    int base;
    int ibit[8] = '{0, 1, 3, 4, 6, 7, 2, 5};
    always #4 mclk = ~mclk;
    always @(posedge mclk) if (sro === 1'b1) rcnt++;
    source_model u_src (.mclk(mclk), .rst(rst), .go(go), .kind(kind), .core_events(ev),
        .brownout_reset(bor), .master_clear_pin(pin));
    reset_source_combiner_status u_dut (.mclk(mclk), .rst(rst), .brownout_reset(bor),
        .master_clear_pin(pin), .core_events(ev), .watchdog_fuse_enable(fuse), .reg_req(req),
        .reg_rdata(rdata), .system_reset_out(sro), .watchdog_enable(wde),
        .regulator_sleep_keep(keep), .irq(irq));
    // Variant without the regulator bit, fed the same stimulus
    reset_source_combiner_status #(.has_regulator_bit(1'b0)) u_dut_nr (.mclk(mclk), .rst(rst),
        .brownout_reset(bor), .master_clear_pin(pin), .core_events(ev), .watchdog_fuse_enable(fuse),
        .reg_req(req), .reg_rdata(rdata2), .system_reset_out(), .watchdog_enable(),
        .regulator_sleep_keep(keep2), .irq());
    function automatic logic [15:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction
    // Kinds: 0 trap, 1 illegal, 2 reset instruction, 3 watchdog, 4 sleep, 5 idle, 6 pin, 7 brown-out
    function automatic logic [15:0] after_event(input logic [15:0] v, input int k);
        case (k)
            0: return v | 16'h8000;
            1: return v | 16'h4000;
            2: return v | 16'h0040;
            3: return v | 16'h0010;
            4: return (v & ~16'h0010) | 16'h0008;
            5: return (v & ~16'h0010) | 16'h0004;
            6: return v | 16'h0080;
            default: return (v & ~16'hc05c) | 16'h0002;
        endcase
    endfunction
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        check_count++;
        if (g !== e)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge mclk);
        req <= '0;
    endtask
    // Read data stand for one cycle only, so they are taken just after the answering edge
    task automatic rchk(input logic [3:0] a, input logic [15:0] e);
        @(posedge mclk);
        req <= '{a, 16'h0000, 1'b0, 1'b1};
        @(posedge mclk);
        req <= '0;
        #1 chk(rdata, e);
    endtask
    task automatic fire(input int k);
        @(posedge mclk);
        go <= 1'b1;
        kind <= 3'(k);
        @(posedge mclk);
        go <= 1'b0;
    endtask
    initial
    begin
        fork
            begin
                #100000;
                fail_count++;
                stop_test();
            end
        join_none
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        rchk(CAUSE_OFS, CAUSE_RESET);
        rchk(INT_STATUS_OFS, 16'h0000);
        wr(4'h6, rnd());
        rchk(4'h2, 16'h0000);
        for (int k = 0; k < 8; k++)
        begin
            c = rnd();
            fuse <= c[9];
            base = rcnt;
            wr(CAUSE_OFS, c);
            c = c & CAUSE_IMPL_MASK;
            rchk(CAUSE_OFS, c);
            chk(rdata2, c & ~REGULATOR_MASK);
            chk({15'h0000, keep2}, 16'h0000);
            chk(16'(rcnt - base), 16'h0000);
            chk({14'h0000, wde, keep}, {14'h0000, fuse | c[5], c[8]});
            wr(INT_CLEAR_OFS, 16'h00ff);
            wr(INT_ENABLE_OFS, 16'h00ff);
            base = rcnt;
            fire(k);
            repeat (10) @(posedge mclk);
            c = after_event(c, k);
            rchk(CAUSE_OFS, c);
            chk(16'(rcnt > base), 16'(k != 4 && k != 5));
            rchk(INT_STATUS_OFS, 16'h0001 << ibit[k]);
            chk(16'(irq), 16'h0001);
            wr(INT_ENABLE_OFS, 16'h0000);
            rchk(INT_ENABLE_OFS, 16'h0000);
            chk(16'(irq), 16'h0000);
            wr(INT_CLEAR_OFS, 16'h00ff);
            rchk(INT_STATUS_OFS, 16'h0000);
            $display("test done: event %0d", k);
        end
        wr(CAUSE_OFS, 16'hffff);
        fork
            fire(0);
            begin
                @(posedge mclk);
                wr(CAUSE_OFS, 16'h0000);
            end
        join
        repeat (4) @(posedge mclk);
        rchk(CAUSE_OFS, 16'h8000);
        $display("test done: same-cycle write");
        wr(CAUSE_OFS, 16'hffff);
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        rchk(CAUSE_OFS, CAUSE_RESET);
        $display("test done: power-on");
        stop_test();
    end
endmodule
